// ==== src/slhp_pkg.sv ====
// Shared types and constants for the serial link host port control.
// Assumes a single system clock; every pin is sampled in that domain.
package slhp_pkg;

   // Parallel character widths
   localparam int CHAR_W = 10;
   localparam int CMD_W  = 4;

   // Transmit queue geometry
   localparam int TXQ_DEPTH = 16;
   localparam int TXQ_LVL_W = 5;
   localparam logic [TXQ_LVL_W-1:0] TXQ_HALF_LEVEL = 5'h08;

   // Reset values
   localparam logic FLAG_IDLE  = 1'b0;
   localparam logic PIN_IDLE   = 1'b1;

   // Serial rate bands
   typedef enum logic {
      SLHP_BAND_LOW,
      SLHP_BAND_HIGH
   } slhp_band_t;

   // Reference prescaler ratios
   localparam logic [1:0] REF_DIV_ONE = 2'h1;
   localparam logic [1:0] REF_DIV_TWO = 2'h2;

   // One transmit or receive character with its qualifiers
   typedef struct packed {
      logic              special;
      logic [CMD_W-1:0]  cmd;
      logic [CHAR_W-1:0] char_val;
   } slhp_word_t;

   localparam int WORD_W = $bits(slhp_word_t);

   // Static configuration straps
   typedef struct packed {
      logic bypass_n;
      logic ext_queue;
      logic rate_band;
      logic prescale;
      logic width;
   } slhp_cfg_t;

   localparam slhp_cfg_t CFG_RESET = 5'h10;

   // Loop multiplier settings handed to the PLLs
   typedef struct packed {
      slhp_band_t band;
      logic [1:0] ref_div;
      logic       wide_char;
   } slhp_vco_t;

   // Every pin that arrives from outside the system clock domain
   typedef struct packed {
      logic       tx_clk;
      logic       rx_clk;
      logic       ref_clk;
      logic       cs_n;
      logic       rx_oe_n;
      logic       tx_en_n;
      logic       mrst_n;
      slhp_cfg_t  cfg;
      slhp_word_t tx_word;
   } slhp_pins_t;

   localparam int PINS_W = $bits(slhp_pins_t);

endpackage

// ==== src/slhp_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides and a fill level.
// Assumes both sides run on the same clock as the instantiating block.
`timescale 1ns/1ps
module slhp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int LVL_W = 5
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             clear,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data,
   // Occupancy
   output logic      [LVL_W-1:0] level
);
   localparam int PTR_W = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [LVL_W-1:0] count;

   wire push = in_valid & in_ready;
   wire pop  = out_valid & out_ready;

   assign in_ready  = (count != LVL_W'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
   assign level     = count;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else if (clear) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + PTR_W'(1);
         end
         if (pop) begin
            rd_ptr <= rd_ptr + PTR_W'(1);
         end
         count <= count + LVL_W'(push) - LVL_W'(pop);
      end
   end

endmodule // slhp_fifo

// ==== src/slhp_port.sv ====
// Host port control of a serial link transceiver: chip-select gating of
// the queue flags and receive drivers, transmit capture, prescaling.
// Assumes the three link clocks arrive as plain pins, slower than clk_sys.
//
// How it works
// R1: Chip select low on a receive clock edge drives the receive flags.
// R2: Receive drivers turn on at a receive clock edge with enable and chip select low.
// R3: Queue in use: chip select on write clock edges gates transmit flags.
// R4: Queue bypassed: chip select on reference edges gates transmit flags.
// R5: Queue in use: capture inputs on each write edge while selected, enabled and not full.
// R6: Bypassed: capture on each reference edge while selected, enabled and not full, pass on.
// R7: Reference clock times both loops and bypassed transmit port.
// R8: Rate band select high picks the fast band, low the slow band.
// R9: Prescale select high halves the reference, low passes it straight.
// R10: Bypassed with prescale high or slow band: full flag toggles.
// R11: Master reset is held low at least one reference cycle.
// R12: Loop settings follow rate band, prescale and character width.
// R13: Bypass keeps the transmit queue in use; transmit uses reference timing.
// R14: Flags active low, or full and empty active high in external mode.
// R15: Configuration is latched only while master reset is held.
`timescale 1ns/1ps
module slhp_port
   import slhp_pkg::*;
(
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // Link clocks and master reset, sampled as pins
   input  wire logic             tx_write_clock,
   input  wire logic             rx_side_clock,
   input  wire logic             pll_reference_clock,
   input  wire logic             master_reset_n,
   // Static configuration pins
   input  wire logic             fifo_bypass_n,
   input  wire logic             external_queue_mode,
   input  wire logic             rate_band_select,
   input  wire logic             ref_prescale_select,
   input  wire logic             char_width_select,
   // Parallel control pins
   input  wire logic             chip_select_n,
   input  wire logic             rx_output_enable_n,
   input  wire logic             tx_input_enable_n,
   // Transmit parallel inputs
   input  wire logic [CHAR_W-1:0] tx_char_in,
   input  wire logic [CMD_W-1:0]  tx_command_in,
   input  wire logic              tx_special_char_select,
   // Transmit word towards the encoder
   output slhp_pkg::slhp_word_t   enc_word,
   output logic                   enc_valid,
   input  wire logic              enc_ready,
   // Decoded receive word and receive queue state
   input  wire slhp_pkg::slhp_word_t rx_word_in,
   input  wire logic              rx_violation_in,
   input  wire logic              rx_queue_full,
   input  wire logic              rx_queue_half,
   input  wire logic              rx_queue_empty,
   // Receive parallel outputs with drive enables
   output logic [CHAR_W-1:0]      rx_char_out,
   output logic [CMD_W-1:0]       rx_command_out,
   output logic                   rx_special_char_flag,
   output logic                   code_violation_flag,
   output logic                   rx_data_oe,
   // Receive flag pins with drive enable
   output logic                   rx_full_pin,
   output logic                   rx_half_pin,
   output logic                   rx_empty_pin,
   output logic                   rx_flag_oe,
   // Transmit flag pins with drive enable
   output logic                   tx_fifo_full_flag,
   output logic                   tx_half_pin,
   output logic                   tx_empty_pin,
   output logic                   tx_flag_oe,
   // Loop control
   output slhp_pkg::slhp_vco_t    vco_setting,
   output logic                   pll_ref_tick,
   output logic                   core_reset
);
   import slhp_pkg::*;

   // Pin synchroniser: stage one feeds stage two only
   slhp_pins_t pins_raw;
   slhp_pins_t pins_meta;
   slhp_pins_t pins;
   slhp_pins_t pins_prev;

   assign pins_raw = '{
      tx_clk:  tx_write_clock,
      rx_clk:  rx_side_clock,
      ref_clk: pll_reference_clock,
      cs_n:    chip_select_n,
      rx_oe_n: rx_output_enable_n,
      tx_en_n: tx_input_enable_n,
      mrst_n:  master_reset_n,
      cfg:     '{bypass_n:  fifo_bypass_n,
                 ext_queue: external_queue_mode,
                 rate_band: rate_band_select,
                 prescale:  ref_prescale_select,
                 width:     char_width_select},
      tx_word: '{special:  tx_special_char_select,
                 cmd:      tx_command_in,
                 char_val: tx_char_in}
   };

   genvar gi;
   generate
      for (gi = 0; gi < PINS_W; gi++) begin : g_sync
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               pins_meta[gi] <= PIN_IDLE;
               pins[gi]      <= PIN_IDLE;
               pins_prev[gi] <= PIN_IDLE;
            end else begin
               pins_meta[gi] <= pins_raw[gi];
               pins[gi]      <= pins_meta[gi];
               pins_prev[gi] <= pins[gi];
            end
         end
      end
   endgenerate

   // Clock edges seen in the system domain
   wire tx_rise  = pins.tx_clk & ~pins_prev.tx_clk;
   wire rx_rise  = pins.rx_clk & ~pins_prev.rx_clk;
   wire ref_rise = pins.ref_clk & ~pins_prev.ref_clk;

   // Master reset; low on the pin clears the queue and edge state and holds the drive enables off
   wire in_reset = ~pins.mrst_n;              // see R11

   // Configuration straps are caught only during master reset
   slhp_cfg_t cfg;
   slhp_cfg_t next_cfg;
   assign next_cfg = in_reset ? pins.cfg : cfg; // see R15

   wire bypass    = ~cfg.bypass_n;              // see R13
   wire ext_mode  = cfg.ext_queue;
   wire fast_band = cfg.rate_band;

   // Prescaler: a reference tick every edge, or every second edge
   logic ref_half;
   wire  ref_tick = ref_rise & (~cfg.prescale | ref_half); // see R9

   // Transmit port edge: write clock, or reference clock when bypassed
   wire tx_edge = bypass ? ref_rise : tx_rise;  // see R7 see R13

   // Chip select as last sampled on each port's own edge
   logic tx_cs;
   logic rx_cs;
   logic tx_en_seen;
   logic rx_oe_seen;

   wire tx_take  = tx_edge & ~pins.cs_n & ~pins.tx_en_n; // see R5 see R6
   wire rx_open  = rx_rise & ~pins.cs_n & ~pins.rx_oe_n & ~rx_oe_seen;
   wire rx_close = rx_rise & pins.rx_oe_n;

   // Transmit queue; bypassed it still holds up to its depth
   logic               txq_ready;
   slhp_word_t         txq_out;
   logic               txq_valid;
   logic [TXQ_LVL_W-1:0] txq_level;

   slhp_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (TXQ_DEPTH),
      .LVL_W (TXQ_LVL_W)
   ) u_txq (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .clear     (in_reset),
      .in_valid  (tx_take),
      .in_ready  (txq_ready),
      .in_data   (pins.tx_word),
      .out_valid (txq_valid),
      .out_ready (enc_ready & ~enc_valid),
      .out_data  (txq_out),
      .level     (txq_level)
   );

   // Raw transmit flag states before polarity
   logic rate_toggle;
   wire  toggle_mode = bypass & (cfg.prescale | ~fast_band); // see R10
   wire  tx_full_raw = toggle_mode ? rate_toggle : ~txq_ready;
   wire  tx_half_raw = (txq_level >= TXQ_HALF_LEVEL);
   wire  tx_empty_raw = ~txq_valid;

   // Full and empty go high-active in external mode; half stays low
   wire tx_full_lvl  = ext_mode ? tx_full_raw : ~tx_full_raw;   // see R14
   wire tx_empty_lvl = ext_mode ? tx_empty_raw : ~tx_empty_raw; // see R14
   wire tx_half_lvl  = ~tx_half_raw;                            // see R14
   wire rx_full_lvl  = ext_mode ? rx_queue_full : ~rx_queue_full;
   wire rx_empty_lvl = ext_mode ? rx_queue_empty : ~rx_queue_empty;
   wire rx_half_lvl  = ~rx_queue_half;

   // Loop settings from the three straps
   slhp_vco_t next_vco;
   assign next_vco = '{
      band:      fast_band ? SLHP_BAND_HIGH : SLHP_BAND_LOW, // see R8
      ref_div:   cfg.prescale ? REF_DIV_TWO : REF_DIV_ONE,    // see R9
      wide_char: ~cfg.width                                   // see R12
   };

   // Encoder hand-off register
   wire enc_load = txq_valid & enc_ready & ~enc_valid;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cfg <= CFG_RESET;
      end else begin
         cfg <= next_cfg;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ref_half    <= FLAG_IDLE;
         rate_toggle <= FLAG_IDLE;
         pll_ref_tick <= FLAG_IDLE;
      end else if (in_reset) begin
         ref_half    <= FLAG_IDLE;
         rate_toggle <= FLAG_IDLE;
         pll_ref_tick <= FLAG_IDLE;
      end else begin
         ref_half     <= ref_rise ? ~ref_half : ref_half;
         rate_toggle  <= ref_rise ? ~rate_toggle : rate_toggle; // see R10
         pll_ref_tick <= ref_tick;                              // see R7
      end
   end

   // Chip select capture per clock
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_cs      <= FLAG_IDLE;
         rx_cs      <= FLAG_IDLE;
         tx_en_seen <= FLAG_IDLE;
         rx_oe_seen <= FLAG_IDLE;
      end else if (in_reset) begin
         tx_cs      <= FLAG_IDLE;
         rx_cs      <= FLAG_IDLE;
         tx_en_seen <= FLAG_IDLE;
         rx_oe_seen <= FLAG_IDLE;
      end else begin
         if (tx_edge) begin
            tx_cs      <= ~pins.cs_n;                // see R3 see R4
            tx_en_seen <= ~pins.tx_en_n;
         end
         if (rx_rise) begin
            rx_cs <= ~pins.cs_n;                     // see R1
         end
         if (rx_open) begin
            rx_oe_seen <= 1'b1;                      // see R2
         end else if (rx_close) begin
            rx_oe_seen <= FLAG_IDLE;                 // see R2
         end
      end
   end

   // Receive data drivers and their captured values
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_char_out          <= '0;
         rx_command_out       <= '0;
         rx_special_char_flag <= FLAG_IDLE;
         code_violation_flag  <= FLAG_IDLE;
         rx_data_oe           <= FLAG_IDLE;
      end else begin
         rx_data_oe <= (rx_oe_seen | rx_open) & ~rx_close & ~in_reset;
         if (rx_rise & (rx_oe_seen | rx_open)) begin
            rx_char_out          <= rx_word_in.char_val;
            rx_command_out       <= rx_word_in.cmd;
            rx_special_char_flag <= rx_word_in.special;
            code_violation_flag  <= rx_violation_in;
         end
      end
   end

   // Flag pins and their enables
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_full_pin       <= PIN_IDLE;
         rx_half_pin       <= PIN_IDLE;
         rx_empty_pin      <= PIN_IDLE;
         rx_flag_oe        <= FLAG_IDLE;
         tx_fifo_full_flag <= PIN_IDLE;
         tx_half_pin       <= PIN_IDLE;
         tx_empty_pin      <= PIN_IDLE;
         tx_flag_oe        <= FLAG_IDLE;
      end else begin
         rx_full_pin       <= rx_full_lvl;
         rx_half_pin       <= rx_half_lvl;
         rx_empty_pin      <= rx_empty_lvl;
         rx_flag_oe        <= rx_cs & ~in_reset;     // see R1
         tx_fifo_full_flag <= tx_full_lvl;
         tx_half_pin       <= tx_half_lvl;
         tx_empty_pin      <= tx_empty_lvl;
         tx_flag_oe        <= tx_cs & ~in_reset;     // see R3 see R4
      end
   end

   // Encoder side and loop outputs
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         enc_word    <= '0;
         enc_valid   <= FLAG_IDLE;
         vco_setting <= '0;
         core_reset  <= 1'b1;
      end else begin
         core_reset  <= in_reset;
         vco_setting <= next_vco;                    // see R12
         if (in_reset) begin
            enc_valid <= FLAG_IDLE;
         end else if (enc_load) begin
            enc_word  <= txq_out;                    // see R6
            enc_valid <= 1'b1;
         end else if (enc_ready) begin
            enc_valid <= FLAG_IDLE;
         end
      end
   end

endmodule // slhp_port

// ==== testbench/slhp_enc_sink.sv ====
// Encoder-side sink model for the host port transmit word handshake.
// Assumes the bench picks the mode: 0 prompt, 1 random stalls, 2 hold.
`timescale 1ns/1ps
module slhp_enc_sink (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Behaviour select
   input  wire logic [1:0] mode,
   // Handshake
   output logic            enc_ready
);
   logic [7:0] lfsr;

   // Ready moves off the sampling edge, like any other driver here
   always @(negedge clk_sys or posedge rst) begin
      if (rst) begin
         lfsr      <= 8'h5a;
         enc_ready <= 1'b0;
      end else begin
         lfsr      <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
         enc_ready <= (mode == 2'h0) || (mode == 2'h1 && lfsr[0]);
      end
   end
endmodule // slhp_enc_sink

// ==== testbench/slhp_port_assertions.sv ====
// Concurrent checks on the ports of slhp_port, bound to every instance.
// Assumes link clocks stay at each level at least two clk_sys cycles.
`timescale 1ns/1ps
module slhp_port_chk (
   // Clock and reset
   input wire logic                clk_sys,
   input wire logic                rst,
   // Pins
   input wire logic                master_reset_n,
   input wire logic                chip_select_n,
   input wire logic                rx_output_enable_n,
   // Outputs
   input wire slhp_pkg::slhp_word_t enc_word,
   input wire logic                enc_valid,
   input wire logic                enc_ready,
   input wire logic                rx_data_oe,
   input wire logic                rx_flag_oe,
   input wire logic                tx_flag_oe,
   input wire logic                pll_ref_tick,
   input wire logic                core_reset
);
   import slhp_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_enc_word_hold: assert property (
      enc_valid && !enc_ready |=> enc_valid && $stable(enc_word))
      else $error("encoder word changed while stalled");
   a_enc_load_gap: assert property (
      enc_valid && enc_ready |=> !enc_valid)
      else $error("encoder word reloaded without a gap");
   a_core_rst_hold: assert property (
      !master_reset_n [*6] |-> core_reset)
      else $error("core reset low while master reset held");
   a_oe_off_mrst: assert property (
      !master_reset_n [*6] |-> !rx_data_oe && !rx_flag_oe && !tx_flag_oe)
      else $error("drivers on during master reset");
   a_ref_tick_gap: assert property (
      pll_ref_tick |=> !pll_ref_tick [*3])
      else $error("reference ticks too close");
   a_rx_open_cause: assert property (
      $rose(rx_data_oe) |->
         !$past(chip_select_n, 3) && !$past(rx_output_enable_n, 3))
      else $error("receive drivers opened without select and enable");
   a_rx_close_cause: assert property (
      $fell(rx_data_oe) |->
         $past(rx_output_enable_n, 3) || !$past(master_reset_n, 3))
      else $error("receive drivers closed while still enabled");
   a_rx_flag_sel: assert property (
      $rose(rx_flag_oe) |-> !$past(chip_select_n, 4))
      else $error("receive flags driven while deselected");
   a_tx_flag_sel: assert property (
      $rose(tx_flag_oe) |-> !$past(chip_select_n, 4))
      else $error("transmit flags driven while deselected");

   c_stall: cover property (enc_valid && !enc_ready);
   c_rx_open: cover property ($rose(rx_data_oe));
   c_tx_float: cover property ($fell(tx_flag_oe));
endmodule // slhp_port_chk

bind slhp_port slhp_port_chk i_slhp_port_chk (
   .clk_sys(clk_sys), .rst(rst), .master_reset_n(master_reset_n),
   .chip_select_n(chip_select_n), .rx_output_enable_n(rx_output_enable_n),
   .enc_word(enc_word), .enc_valid(enc_valid), .enc_ready(enc_ready),
   .rx_data_oe(rx_data_oe), .rx_flag_oe(rx_flag_oe),
   .tx_flag_oe(tx_flag_oe), .pll_ref_tick(pll_ref_tick),
   .core_reset(core_reset)
);

// ==== testbench/slhp_port_tb_top.sv ====
// Self-checking bench for slhp_port with the encoder sink model.
// Assumes link clock high phases of three clk_sys cycles, low phases of at least five, set at falling edges.
`timescale 1ns/1ps
module slhp_port_tb_top;
   import slhp_pkg::*;
   logic              clk_sys = 1'b0;
   logic              rst = 1'b1;
   logic              tx_write_clock, rx_side_clock, pll_reference_clock;
   logic              master_reset_n, chip_select_n;
   logic              rx_output_enable_n, tx_input_enable_n;
   logic              fifo_bypass_n, external_queue_mode, rate_band_select;
   logic              ref_prescale_select, char_width_select;
   logic [CHAR_W-1:0] tx_char_in, rx_char_out;
   logic [CMD_W-1:0]  tx_command_in, rx_command_out;
   logic              tx_special_char_select, enc_valid, enc_ready;
   logic              rx_violation_in, rx_queue_full, rx_queue_half;
   logic              rx_queue_empty, rx_special_char_flag;
   logic              code_violation_flag, rx_data_oe, rx_full_pin;
   logic              rx_half_pin, rx_empty_pin, rx_flag_oe;
   logic              tx_fifo_full_flag, tx_half_pin, tx_empty_pin;
   logic              tx_flag_oe, pll_ref_tick, core_reset;
   slhp_word_t        enc_word, rx_word_in;
   slhp_vco_t         vco_setting;
   logic [1:0]        sink_mode;
   int                n_errors = 0;
   int                cmp_count = 0;
   int                n_ticks = 0;
   slhp_word_t        exp_q[$];

   always #20 clk_sys = ~clk_sys;

   slhp_port i_slhp_port (
      .clk_sys, .rst, .tx_write_clock, .rx_side_clock, .pll_reference_clock,
      .master_reset_n, .fifo_bypass_n, .external_queue_mode,
      .rate_band_select, .ref_prescale_select, .char_width_select,
      .chip_select_n, .rx_output_enable_n, .tx_input_enable_n, .tx_char_in,
      .tx_command_in, .tx_special_char_select, .enc_word, .enc_valid,
      .enc_ready, .rx_word_in, .rx_violation_in, .rx_queue_full,
      .rx_queue_half, .rx_queue_empty, .rx_char_out, .rx_command_out,
      .rx_special_char_flag, .code_violation_flag, .rx_data_oe,
      .rx_full_pin, .rx_half_pin, .rx_empty_pin, .rx_flag_oe,
      .tx_fifo_full_flag, .tx_half_pin, .tx_empty_pin, .tx_flag_oe,
      .vco_setting, .pll_ref_tick, .core_reset
   );

   slhp_enc_sink i_slhp_enc_sink (
      .clk_sys, .rst, .mode(sink_mode), .enc_ready
   );

   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_word(slhp_word_t exp, slhp_word_t got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD word expected %h seen %h", exp, got);
      end
   endtask

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Lead and phases of three cycles keep pins settled around each edge;
   // the tail covers the output register stage that follows the two sync stages and the capture stage
   task automatic pulse(ref logic c);
      repeat (3) @(negedge clk_sys);
      c = 1'b1;
      repeat (3) @(negedge clk_sys);
      c = 1'b0;
      repeat (2) @(negedge clk_sys);
   endtask

   // Cap of 16 only matters in hold mode, where nothing drains
   task automatic send(int n, logic byp);
      slhp_word_t w;
      logic       f;
      for (int i = 0; i < n; i++) begin
         w = WORD_W'($urandom);
         {tx_special_char_select, tx_command_in, tx_char_in} = w;
         f = tx_fifo_full_flag;
         if (!chip_select_n && !tx_input_enable_n && exp_q.size() < TXQ_DEPTH)
            exp_q.push_back(w);
         if (byp) pulse(pll_reference_clock);
         else pulse(tx_write_clock);
         if (byp && !chip_select_n)
            chk("full toggle", !f, tx_fifo_full_flag);
      end
   endtask

   // c packs bypass_n, external mode, band, prescale, width
   task automatic mrst(logic [4:0] c);
      {fifo_bypass_n, external_queue_mode, rate_band_select,
       ref_prescale_select, char_width_select} = c;
      master_reset_n = 1'b0;
      pulse(pll_reference_clock);
      master_reset_n = 1'b1;
      repeat (6) @(negedge clk_sys);
      chk("vco", {c[2], c[1] ? REF_DIV_TWO : REF_DIV_ONE, !c[0]},
          vco_setting);
      chk("core reset", 0, core_reset);
   endtask

   always @(posedge clk_sys) begin
      if (pll_ref_tick === 1'b1) n_ticks++;
   end

   always @(posedge clk_sys) begin
      if (!rst && enc_valid === 1'b1 && enc_ready === 1'b1) begin
         if (exp_q.size() == 0) chk("spare word", 0, 16'hffff);
         else chk_word(exp_q.pop_front(), enc_word);
      end
   end

   // Some 534 cycles are needed; ten thousand means a hang
   initial begin
      #400000;
      n_errors++;
      give_verdict();
   end

   initial begin
      void'($urandom(21421));
      {tx_write_clock, rx_side_clock, pll_reference_clock} = 3'h0;
      {master_reset_n, chip_select_n} = 2'h3;
      {rx_output_enable_n, tx_input_enable_n} = 2'h3;
      {fifo_bypass_n, external_queue_mode, rate_band_select,
       ref_prescale_select, char_width_select} = 5'h10;
      {tx_special_char_select, tx_command_in, tx_char_in} = '0;
      rx_word_in = '0;
      {rx_violation_in, rx_queue_full, rx_queue_half, rx_queue_empty} = 4'h0;
      sink_mode = 2'h0;
      repeat (8) @(negedge clk_sys);
      chk("reset outs", 16'h0003,
          {vco_setting, rx_data_oe, rx_flag_oe, tx_flag_oe, enc_valid,
           tx_fifo_full_flag, core_reset});
      rst = 1'b0;
      for (int i = 0; i < 8; i++) mrst({2'h2, 3'(i)});
      chip_select_n = 1'b0;
      tx_input_enable_n = 1'b0;
      sink_mode = 2'h1;
      send(6, 1'b0);
      chk("tx flag oe", 1, tx_flag_oe);
      chip_select_n = 1'b1;
      send(3, 1'b0);
      chk("tx flag oe", 0, tx_flag_oe);
      chip_select_n = 1'b0;
      tx_input_enable_n = 1'b1;
      send(2, 1'b0);
      repeat (20) @(negedge clk_sys);
      sink_mode = 2'h2;
      tx_input_enable_n = 1'b0;
      send(18, 1'b0);
      chk("full low", 0, tx_fifo_full_flag);
      chk("half low", 0, tx_half_pin);
      sink_mode = 2'h0;
      repeat (60) @(negedge clk_sys);
      chk("left over", 0, 16'(exp_q.size()));
      chk("empty low", 0, tx_empty_pin);
      tx_input_enable_n = 1'b1;
      mrst(5'h0e);
      tx_input_enable_n = 1'b0;
      n_ticks = 0;
      send(6, 1'b1);
      chk("ref ticks", 16'h0003, 16'(n_ticks));
      chk("tx flag oe", 1, tx_flag_oe);
      chip_select_n = 1'b1;
      send(1, 1'b1);
      chk("tx flag oe", 0, tx_flag_oe);
      tx_input_enable_n = 1'b1;
      for (int i = 0; i < 4; i++) begin
         rx_word_in = WORD_W'($urandom);
         {rx_violation_in, rx_queue_full, rx_queue_half, rx_queue_empty} =
            4'($urandom);
         chip_select_n = (i == 3);
         rx_output_enable_n = (i == 2);
         pulse(rx_side_clock);
         chk("rx data oe", i < 2, rx_data_oe);
         chk("rx flag oe", i != 3, rx_flag_oe);
         if (i < 2) begin
            chk_word(rx_word_in, {rx_special_char_flag, rx_command_out,
                                  rx_char_out});
            chk("violation", rx_violation_in, code_violation_flag);
         end
         if (i != 3)
            chk("rx flags", {rx_queue_full, !rx_queue_half, rx_queue_empty},
                {rx_full_pin, rx_half_pin, rx_empty_pin});
      end
      give_verdict();
   end
endmodule // slhp_port_tb_top
